// ---- core/smpc_pkg.sv ----
package smpc_pkg;

  // ---------------------------------------------------------------
  // Clocking and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned REF_HZ = 288000;
  localparam int unsigned REF_DIV = (CLK_HZ + REF_HZ / 2) / REF_HZ;
  localparam int unsigned BREAK_MS = 200;
  localparam int unsigned BREAK_CYCLES = (CLK_HZ / 1000) * BREAK_MS;
  localparam int unsigned OVERSAMPLE = 16;

  // ---------------------------------------------------------------
  // Rate selection and counter presets
  // ---------------------------------------------------------------
  typedef logic [2:0] smpc_baud_t;
  localparam smpc_baud_t BAUD_110 = 3'h0;
  localparam smpc_baud_t BAUD_300 = 3'h1;
  localparam smpc_baud_t BAUD_1200 = 3'h2;
  localparam smpc_baud_t BAUD_1800 = 3'h3;
  localparam smpc_baud_t BAUD_2000 = 3'h4;
  localparam logic [3:0] PRE1_15 = 4'hf;
  localparam logic [3:0] PRE1_10 = 4'ha;
  localparam logic [3:0] PRE1_9 = 4'h9;
  localparam logic [3:0] PRE2_11 = 4'hb;
  localparam logic [3:0] PRE2_4 = 4'h4;
  localparam logic [3:0] PRE2_1 = 4'h1;

  // ---------------------------------------------------------------
  // Parity selection
  // ---------------------------------------------------------------
  typedef logic [1:0] smpc_par_t;
  localparam smpc_par_t PAR_OFF = 2'h0;
  localparam smpc_par_t PAR_ODD = 2'h1;
  localparam smpc_par_t PAR_EVEN = 2'h2;
  localparam logic [3:0] BITS_NOPAR = 4'h8;
  localparam logic [3:0] BITS_PAR = 4'h7;

  // ---------------------------------------------------------------
  // Command codes {bit7, bit6, bit5, bit0}
  // ---------------------------------------------------------------
  typedef logic [3:0] smpc_cmd_t;
  localparam smpc_cmd_t CMD_MRESET = 4'h2;
  localparam smpc_cmd_t CMD_BREAK = 4'h3;
  localparam smpc_cmd_t CMD_DTR_ON = 4'h8;
  localparam smpc_cmd_t CMD_RTS_ON = 4'h9;
  localparam smpc_cmd_t CMD_RX_ON = 4'ha;
  localparam smpc_cmd_t CMD_TX_ON = 4'hb;
  localparam smpc_cmd_t CMD_DTR_OFF = 4'hc;
  localparam smpc_cmd_t CMD_RTS_OFF = 4'hd;
  localparam smpc_cmd_t CMD_RX_OFF = 4'he;
  localparam smpc_cmd_t CMD_TX_OFF = 4'hf;

  // ---------------------------------------------------------------
  // Response bus bit positions
  // ---------------------------------------------------------------
  localparam int unsigned RB_CD = 0;
  localparam int unsigned RB_MODE = 0;
  localparam int unsigned RB_TXAV = 3;
  localparam int unsigned RB_RING = 4;
  localparam int unsigned RB_PE = 5;
  localparam int unsigned RB_FE = 6;
  localparam int unsigned RB_OE = 7;

  // ---------------------------------------------------------------
  // Serial state machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PAR = 5'h08,
    SER_STOP = 5'h10
  } smpc_ser_t;

  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;

  // Parity of a character under the selected mode
  function automatic logic smpc_parity(input logic [7:0] d, input smpc_par_t sel);
    smpc_parity = ^d[6:0] ^ (sel == PAR_ODD);
  endfunction

endpackage

// ---- core/smpc_shift_clock.sv ----
`timescale 1ns/10ps
module smpc_shift_clock #(
  parameter int unsigned REF_COUNT = smpc_pkg::REF_DIV
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] preset1_in,
  input wire logic [3:0] preset2_in,
  output logic serial_shift_clock_out
);
  import smpc_pkg::*;

  logic [7:0] ref_cnt_q;
  logic [3:0] st1_q;
  logic [3:0] st2_q;
  wire reference_divider_input = (ref_cnt_q == 8'(REF_COUNT - 1));
  wire st1_wrap = reference_divider_input && (st1_q >= preset1_in - 4'h1);
  wire st2_wrap = st1_wrap && (st2_q >= preset2_in - 4'h1);

  // ---------------------------------------------------------------
  // Reference tick, then two cascaded preset stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_cnt_q <= 8'h00;
      st1_q <= 4'h0;
      st2_q <= 4'h0;
      serial_shift_clock_out <= 1'b0;
    end else begin
      ref_cnt_q <= reference_divider_input ? 8'h00 : ref_cnt_q + 8'h01;
      if (reference_divider_input) begin
        st1_q <= st1_wrap ? 4'h0 : st1_q + 4'h1;
      end
      if (st1_wrap) begin
        st2_q <= st2_wrap ? 4'h0 : st2_q + 4'h1;
      end
      serial_shift_clock_out <= st2_wrap;
    end
  end

endmodule

// ---- core/smpc_top.sv ----
`timescale 1ns/10ps
// How it works
// - Codes 0000/0001 read status; 01xx do nothing
// - 0010 master reset; 0011 fires break
// - 10xx turn on DTR, RTS, receiver, transmitter
// - 11xx turn off DTR, RTS, receiver, transmitter
// - Status: carrier, transmitter available, ring indicator
// - Poll: mode bit, card address, error flags
// - Shift clock: 288 kHz through two stages
// - Rate selects the two counter presets
// - Inverted line data reaches receiver only with carrier
// - Line low for mark, high for space/break
// - Break holds space about 200 ms
// - Parity off: no parity, eight bits
// - Odd: parity on, seven bits, odd
// - Even: parity on, seven bits, even
// - Commands act only on matching card address
// - Framing: missing stop; overrun: unread character
module smpc_top #(
  parameter int unsigned BREAK_LEN = smpc_pkg::BREAK_CYCLES,
  parameter int unsigned REF_COUNT = smpc_pkg::REF_DIV
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] host_address_in,
  input wire logic [3:0] card_address_in,
  input wire logic stat_in,
  input wire logic poll_in,
  input wire logic io_data_transfer_in,
  input wire smpc_pkg::smpc_baud_t baud_sel_in,
  input wire smpc_pkg::smpc_par_t parity_sel_in,
  input wire logic carrier_detect_in,
  input wire logic ring_indicator_in,
  input wire logic clear_to_send_in,
  input wire logic line_rx_in,
  output logic line_tx_out,
  output logic dtr_out,
  output logic rts_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic [7:0] response_bus_out,
  output logic response_valid_out
);
  import smpc_pkg::*;

  // ---------------------------------------------------------------
  // Shift clock and character format
  // ---------------------------------------------------------------
  wire is_110 = (baud_sel_in == BAUD_110);
  wire is_300 = (baud_sel_in == BAUD_300);
  wire is_1800 = (baud_sel_in == BAUD_1800);
  wire is_2000 = (baud_sel_in == BAUD_2000);
  wire [3:0] preset1 = is_1800 ? PRE1_10 : (is_2000 ? PRE1_9 : PRE1_15);
  wire [3:0] preset2 = is_110 ? PRE2_11 : (is_300 ? PRE2_4 : PRE2_1);
  wire tick;
  wire par_on = (parity_sel_in != PAR_OFF);
  wire [3:0] char_bits = par_on ? BITS_PAR : BITS_NOPAR;

  smpc_shift_clock #(.REF_COUNT(REF_COUNT)) u_clk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .preset1_in(preset1),
    .preset2_in(preset2),
    .serial_shift_clock_out(tick)
  );

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire addr_hit = (host_address_in[4:1] == card_address_in);
  wire cmd_go = stat_in && addr_hit;
  wire [3:0] cmd = {host_address_in[7:5], host_address_in[0]};
  wire mreset = cmd_go && (cmd == CMD_MRESET);
  wire brk_fire = cmd_go && (cmd == CMD_BREAK);

  logic dtr_q, rts_q, rx_en_q, tx_en_q;
  logic [22:0] brk_cnt_q;
  wire brk_on = (brk_cnt_q != 23'h0);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      brk_cnt_q <= 23'h0;
    end else if (mreset) begin
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      brk_cnt_q <= 23'h0;
    end else begin
      if (cmd_go && cmd[3]) begin
        unique case (cmd)
          CMD_DTR_ON: dtr_q <= 1'b1;
          CMD_RTS_ON: rts_q <= 1'b1;
          CMD_RX_ON: rx_en_q <= 1'b1;
          CMD_TX_ON: tx_en_q <= 1'b1;
          CMD_DTR_OFF: dtr_q <= 1'b0;
          CMD_RTS_OFF: rts_q <= 1'b0;
          CMD_RX_OFF: rx_en_q <= 1'b0;
          default: tx_en_q <= 1'b0;
        endcase
      end
      if (brk_fire) begin
        brk_cnt_q <= 23'(BREAK_LEN);
      end else if (brk_on) begin
        brk_cnt_q <= brk_cnt_q - 23'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  wire rx_line = carrier_detect_in ? ~line_rx_in : 1'b1;
  smpc_ser_t rx_st_q;
  logic [3:0] rx_tick_q, rx_n_q;
  logic [7:0] rx_sh_q, rx_data_q;
  logic rx_par_q, rx_rdy_q, pe_q, fe_q, oe_q;
  wire rx_last = (rx_tick_q == TICK_LAST);
  wire rx_bits_done = (rx_n_q == char_bits - 4'h1);
  wire [7:0] rx_char = par_on ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
  logic rx_sel_q, tx_sel_q;
  wire rx_take = io_data_transfer_in && rx_sel_q;
  wire rx_done = tick && rx_last && (rx_st_q == SER_STOP);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_q <= SER_IDLE;
      rx_tick_q <= 4'h0;
      rx_n_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_rdy_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data_q <= rx_char;
        rx_rdy_q <= 1'b1;
        fe_q <= ~rx_line;
        oe_q <= rx_rdy_q && !rx_take;
        pe_q <= par_on && (rx_par_q != smpc_parity(rx_char, parity_sel_in));
      end else if (mreset) begin
        rx_rdy_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (rx_take) begin
        rx_rdy_q <= 1'b0;
      end
      if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        unique case (rx_st_q)
          SER_IDLE: begin
            rx_tick_q <= 4'h0;
            if (!rx_line) rx_st_q <= SER_START;
          end
          SER_START: begin
            if (rx_tick_q == TICK_MID) begin
              rx_tick_q <= 4'h0;
              rx_n_q <= 4'h0;
              rx_st_q <= rx_line ? SER_IDLE : SER_DATA;
            end
          end
          SER_DATA: begin
            if (rx_last) begin
              rx_sh_q <= {rx_line, rx_sh_q[7:1]};
              rx_n_q <= rx_n_q + 4'h1;
              if (rx_bits_done) rx_st_q <= par_on ? SER_PAR : SER_STOP;
            end
          end
          SER_PAR: begin
            if (rx_last) begin
              rx_par_q <= rx_line;
              rx_st_q <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (rx_last) rx_st_q <= SER_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  smpc_ser_t tx_st_q;
  logic [3:0] tx_tick_q, tx_n_q;
  logic [7:0] tx_hold_q, tx_sh_q;
  logic tx_full_q, tx_out_q, tx_par_q;
  wire tx_last = (tx_tick_q == TICK_LAST);
  wire tx_avail = clear_to_send_in && !tx_full_q && tx_en_q && !brk_on;
  wire tx_load = io_data_transfer_in && tx_sel_q;
  wire tx_start = tick && (tx_st_q == SER_IDLE) && tx_full_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_q <= SER_IDLE;
      tx_tick_q <= 4'h0;
      tx_n_q <= 4'h0;
      tx_hold_q <= 8'h00;
      tx_sh_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_out_q <= 1'b1;
      tx_par_q <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_hold_q <= host_address_in;
        tx_full_q <= 1'b1;
      end else if (tx_start || mreset) begin
        tx_full_q <= 1'b0;
      end
      if (tick) begin
        tx_tick_q <= tx_tick_q + 4'h1;
        unique case (tx_st_q)
          SER_IDLE: begin
            tx_tick_q <= 4'h0;
            tx_out_q <= 1'b1;
            if (tx_full_q) begin
              tx_sh_q <= tx_hold_q;
              tx_par_q <= smpc_parity(tx_hold_q, parity_sel_in);
              tx_out_q <= 1'b0;
              tx_st_q <= SER_START;
            end
          end
          SER_START: begin
            if (tx_last) begin
              tx_n_q <= 4'h0;
              tx_out_q <= tx_sh_q[0];
              tx_st_q <= SER_DATA;
            end
          end
          SER_DATA: begin
            if (tx_last) begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_n_q <= tx_n_q + 4'h1;
              tx_out_q <= tx_sh_q[1];
              if (tx_n_q == char_bits - 4'h1) begin
                tx_out_q <= par_on ? tx_par_q : 1'b1;
                tx_st_q <= par_on ? SER_PAR : SER_STOP;
              end
            end
          end
          SER_PAR: begin
            if (tx_last) begin
              tx_out_q <= 1'b1;
              tx_st_q <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (tx_last) tx_st_q <= SER_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Host responses
  // ---------------------------------------------------------------
  wire rx_mode = rx_rdy_q && rx_en_q;
  wire poll_hit = poll_in && (rx_mode || tx_avail);
  wire stat_read = cmd_go && !cmd[3] && !cmd[2] && !cmd[1];
  wire [2:0] errs = {oe_q, fe_q, pe_q};
  wire [7:0] stat_word = {errs, ring_indicator_in, tx_avail, 2'b00, carrier_detect_in};
  wire [7:0] poll_word = {errs, card_address_in, rx_mode};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_sel_q <= 1'b0;
      tx_sel_q <= 1'b0;
      response_bus_out <= 8'h00;
      response_valid_out <= 1'b0;
      line_tx_out <= 1'b0;
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
      rx_enable_out <= 1'b0;
      tx_enable_out <= 1'b0;
    end else begin
      response_valid_out <= stat_read || poll_hit || rx_take;
      if (stat_read) begin
        response_bus_out <= stat_word;
      end else if (poll_hit) begin
        response_bus_out <= poll_word;
      end else if (rx_take) begin
        response_bus_out <= rx_data_q;
      end
      if (poll_hit) begin
        rx_sel_q <= rx_mode;
        tx_sel_q <= !rx_mode;
      end else if (io_data_transfer_in || mreset) begin
        rx_sel_q <= 1'b0;
        tx_sel_q <= 1'b0;
      end
      line_tx_out <= ~tx_out_q || brk_on;
      dtr_out <= dtr_q;
      rts_out <= rts_q;
      rx_enable_out <= rx_en_q;
      tx_enable_out <= tx_en_q;
    end
  end

endmodule

// ---- tb/smpc_modem_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------
// Modem with local echo
// ------------------------------------------
module smpc_modem_model (
  input wire logic cd_lvl_in,
  input wire logic cts_lvl_in,
  input wire logic ring_lvl_in,
  input wire logic line_tx_in,
  output logic carrier_detect_out,
  output logic clear_to_send_out,
  output logic ring_indicator_out,
  output logic line_rx_out
);
  assign carrier_detect_out = cd_lvl_in;
  assign clear_to_send_out = cts_lvl_in;
  assign ring_indicator_out = ring_lvl_in;
  // Echo only with carrier up, else idle mark
  assign line_rx_out = cd_lvl_in ? line_tx_in : 1'b0;
endmodule

// ---- tb/smpc_top_props.sv ----
`timescale 1ns/10ps
// ------------------------------------------
// Port checker
// ------------------------------------------
module smpc_top_props #(
  parameter int unsigned BREAK_LEN = 50
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] host_address_in,
  input wire logic [3:0] card_address_in,
  input wire logic stat_in,
  input wire logic poll_in,
  input wire logic io_data_transfer_in,
  input wire smpc_pkg::smpc_baud_t baud_sel_in,
  input wire smpc_pkg::smpc_par_t parity_sel_in,
  input wire logic carrier_detect_in,
  input wire logic ring_indicator_in,
  input wire logic clear_to_send_in,
  input wire logic line_rx_in,
  input wire logic line_tx_out,
  input wire logic dtr_out,
  input wire logic rts_out,
  input wire logic rx_enable_out,
  input wire logic tx_enable_out,
  input wire logic [7:0] response_bus_out,
  input wire logic response_valid_out
);
  import smpc_pkg::*;
  wire logic [3:0] cmd_w = {host_address_in[7:5], host_address_in[0]};
  wire logic hit_w = stat_in && (host_address_in[4:1] == card_address_in);
  wire logic rd_w = hit_w && (cmd_w[3:1] == 3'h0);
  wire logic quiet_w = !poll_in && !io_data_transfer_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_dtr_set: assert property (hit_w && cmd_w == CMD_DTR_ON |-> ##2 dtr_out)
    else $error("dtr not set");
  a_rx_off: assert property (hit_w && cmd_w == CMD_RX_OFF |-> ##2 !rx_enable_out)
    else $error("receiver not off");
  a_status_word: assert property (rd_w |=> response_valid_out
    && response_bus_out[2:1] == 2'h0 && response_bus_out[RB_CD] == $past(carrier_detect_in)
    && response_bus_out[RB_RING] == $past(ring_indicator_in))
    else $error("bad status word");
  a_silent_cmd: assert property (hit_w && !rd_w && quiet_w |=> !response_valid_out)
    else $error("answer to set command");
  a_foreign_addr: assert property (stat_in && !hit_w && quiet_w |=> !response_valid_out)
    else $error("answer to other card");
  a_break_hold: assert property (hit_w && cmd_w == CMD_BREAK |-> ##[1:3] line_tx_out[*8])
    else $error("break not held");
  a_reset_clear: assert property (hit_w && cmd_w == CMD_MRESET |-> ##2
    !dtr_out && !rts_out && !rx_enable_out && !tx_enable_out)
    else $error("controls not cleared");
  a_txav_cts: assert property (rd_w && !clear_to_send_in |=> !response_bus_out[RB_TXAV])
    else $error("available without cts");
  a_poll_addr: assert property (poll_in && !stat_in && !io_data_transfer_in ##1
    response_valid_out |-> response_bus_out[4:1] == card_address_in)
    else $error("poll address wrong");
endmodule

bind smpc_top smpc_top_props #(.BREAK_LEN(BREAK_LEN)) u_props (.*);

// ---- tb/test_serial_modem_port_control.sv ----
`timescale 1ns/10ps
// ------------------------------------------
// Bench
// ------------------------------------------
module test_serial_modem_port_control;
  import smpc_pkg::*;
  localparam int unsigned BREAK_LEN = 50;
  localparam int unsigned REF_CNT = 1;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] host_address_in = 8'h00;
  logic [3:0] card_address_in = 4'h0;
  logic stat_in = 1'b0;
  logic poll_in = 1'b0;
  logic io_data_transfer_in = 1'b0;
  smpc_baud_t baud_sel_in = BAUD_2000;
  smpc_par_t parity_sel_in = PAR_OFF;
  logic cd_lvl = 1'b0, cts_lvl = 1'b0, ring_lvl = 1'b0;
  logic carrier_detect_in, ring_indicator_in, clear_to_send_in, line_rx_in;
  logic line_tx_out, dtr_out, rts_out, rx_enable_out, tx_enable_out, response_valid_out;
  logic [7:0] response_bus_out;
  wire logic [3:0] ctl_w = {tx_enable_out, rx_enable_out, rts_out, dtr_out};
  logic [7:0] exp_q[$];
  logic [3:0] ctl = 4'h0;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  int tk;
  logic [7:0] ch;
  logic [7:0] rx_exp;
  logic b7;
  // Cycles between shift clock pulses for a rate
  function automatic int tick_len(input smpc_baud_t b);
    case (b)
      BAUD_110: tick_len = 15 * 11 * REF_CNT;
      BAUD_300: tick_len = 15 * 4 * REF_CNT;
      BAUD_1800: tick_len = 10 * REF_CNT;
      BAUD_2000: tick_len = 9 * REF_CNT;
      default: tick_len = 15 * REF_CNT;
    endcase
  endfunction
  always #12.5 clk_in = ~clk_in;
  smpc_top #(.BREAK_LEN(BREAK_LEN), .REF_COUNT(REF_CNT)) dut (.*);
  smpc_modem_model modem (.cd_lvl_in(cd_lvl), .cts_lvl_in(cts_lvl), .ring_lvl_in(ring_lvl),
    .line_tx_in(line_tx_out), .carrier_detect_out(carrier_detect_in),
    .clear_to_send_out(clear_to_send_in), .ring_indicator_out(ring_indicator_in),
    .line_rx_out(line_rx_in));
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [3:0] a);
    host_address_in = {c[3:1], a, c[0]};
    stat_in = 1'b1;
    tick(1);
    stat_in = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Response monitor takes the oldest note
  always @(negedge clk_in) begin
    if (response_valid_out === 1'b1) begin
      check_val(response_bus_out, exp_q.size() ? exp_q.pop_front() : 8'hxx, "resp");
    end
  end
  initial begin
    repeat (200 * tick_len(BAUD_110) + 2000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h3f7d));
    card_address_in = 4'($urandom);
    baud_sel_in = smpc_baud_t'($urandom % 5);
    parity_sel_in = smpc_par_t'($urandom % 3);
    tk = tick_len(baud_sel_in);
    tick(3);
    rst_n_in = 1'b1;
    check_val({3'h0, line_tx_out, ctl_w}, 8'h00, "reset");
    for (int c = 8; c < 16; c++) begin
      cmd(4'(c), card_address_in);
      ctl[c % 4] = (c < 12);
      tick(1);
      check_val(8'(ctl_w), 8'(ctl), "control");
    end
    cmd(CMD_DTR_ON, card_address_in ^ 4'(1 + $urandom % 15));
    tick(2);
    check_val(8'(ctl_w), 8'(ctl), "foreign");
    for (int c = 4; c < 8; c++) begin
      cmd(4'(c), card_address_in);
      tick(1);
    end
    check_val(8'(ctl_w), 8'(ctl), "unused codes");
    cd_lvl = 1'b1;
    ring_lvl = 1'b1;
    cmd(CMD_TX_ON, card_address_in);
    tick(3);
    exp_q.push_back(8'h11);
    cmd(4'h0, card_address_in);
    cts_lvl = 1'b1;
    tick(3);
    exp_q.push_back(8'h19);
    cmd(4'h1, card_address_in);
    tick(2);
    exp_q.push_back({3'h0, card_address_in, 1'b0});
    poll_in = 1'b1;
    tick(1);
    poll_in = 1'b0;
    tick(1);
    ch = 8'($urandom) | 8'h01;
    host_address_in = ch;
    io_data_transfer_in = 1'b1;
    tick(1);
    io_data_transfer_in = 1'b0;
    n = 0;
    while (line_tx_out !== 1'b1 && n < 4 * tk) begin
      tick(1);
      n++;
    end
    n = 0;
    while (line_tx_out === 1'b1 && n < 40 * tk) begin
      tick(1);
      n++;
    end
    check_val(8'(n > 15 * tk && n <= 17 * tk), 8'h1, "start bit");
    b7 = (parity_sel_in == PAR_OFF) ? ch[7] : ((parity_sel_in == PAR_ODD) ? ~^ch[6:0] : ^ch[6:0]);
    rx_exp = (parity_sel_in == PAR_OFF) ? ch : {1'b0, ch[6:0]};
    tick(120 * tk);
    check_val(8'(line_tx_out), 8'(!b7), "bit seven");
    tick(16 * tk);
    check_val(8'(line_tx_out), 8'h00, "stop bit");
    tick(4 * tk);
    cmd(CMD_RX_ON, card_address_in);
    exp_q.push_back({3'h0, card_address_in, 1'b1});
    poll_in = 1'b1;
    tick(1);
    poll_in = 1'b0;
    tick(1);
    exp_q.push_back(rx_exp);
    io_data_transfer_in = 1'b1;
    tick(1);
    io_data_transfer_in = 1'b0;
    tick(2);
    cmd(CMD_BREAK, card_address_in);
    n = 0;
    while (line_tx_out !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    n = 0;
    while (line_tx_out === 1'b1 && n < 4 * BREAK_LEN) begin
      tick(1);
      n++;
    end
    check_val(8'(n), 8'(BREAK_LEN), "break");
    cmd(CMD_RTS_ON, card_address_in);
    tick(1);
    cmd(CMD_MRESET, card_address_in);
    tick(1);
    check_val(8'(ctl_w), 8'h00, "master reset");
    tick(2);
    check_val(8'(exp_q.size()), 8'h00, "missing response");
    tally_and_finish();
  end
endmodule
